// File: testbench/rtcwd_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module rtcwd_pin_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic       i_toggle,
   input  wire logic [7:0] i_port_next,
   input  wire logic       i_port_load,
   output var  logic       o_counter_pin,
   output var  logic [7:0] o_port_b
);
   // levels only move on request and then hold, so each one outlasts the two-flop sampler
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_counter_pin <= 1'b0;
      end
      else if (i_toggle)
      begin
         o_counter_pin <= ~o_counter_pin;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_port_b <= 8'h00;
      end
      else if (i_port_load)
      begin
         o_port_b <= i_port_next;
      end
   end
endmodule : rtcwd_pin_model

`default_nettype wire

// File: testbench/rtcwd_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcwd_consts.svh"

module rtcwd_unit_bench;
   import rtcwd_pkg::*;
   localparam int DRT = 2;
   logic           i_ref_clk = 1'b0;
   logic           i_rst     = 1'b1;
   rtcwd_addr_type i_addr    = 3'h0;
   rtcwd_byte_type i_wdata   = 8'h00;
   logic           i_wr      = 1'b0;
   logic           i_rd      = 1'b0;
   logic           ext_n     = 1'b0;
   logic           brown     = 1'b0;
   logic           wd_fuse   = 1'b0;
   logic           opt_ext   = 1'b0;
   logic           tog       = 1'b0;
   logic           port_ld   = 1'b0;
   logic [7:0]     port_nx   = 8'h00;
   wire            cnt_pin;
   wire [7:0]      port_b;
   rtcwd_byte_type rdata;
   rtcwd_pc_type   pc_vec;
   logic           roll_irq, edge_irq, core_rst, pc_load, to_flag, pd_flag;
   int             mismatches = 0;
   int             samples_checked = 0;
   int             n;

   always #4 i_ref_clk = ~i_ref_clk;

   rtcwd_pin_model PINS (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_toggle(tog),
      .i_port_next(port_nx), .i_port_load(port_ld), .o_counter_pin(cnt_pin),
      .o_port_b(port_b));

   rtcwd_unit #(.DRT_TICK_CYCLES(DRT), .WDT_TICK_CYCLES(1)) DUT (.i_ref_clk(i_ref_clk),
      .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_counter_pin(cnt_pin), .i_port_b(port_b), .i_ext_reset_n(ext_n),
      .i_brownout(brown), .i_watchdog_fuse_enable(wd_fuse),
      .i_option_extend_disable(opt_ext), .o_rdata(rdata), .o_rollover_irq(roll_irq),
      .o_edge_irq(edge_irq), .o_core_reset(core_rst), .o_pc_load(pc_load),
      .o_pc_vector(pc_vec), .o_timeout_flag(to_flag), .o_powerdown_flag(pd_flag));

   task automatic end_of_test();
   begin
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   end
   endtask : end_of_test

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
   begin
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask : chk_val

   task automatic cycles(input int k);
   begin
      repeat (k) @(posedge i_ref_clk);
      #1;
   end
   endtask : cycles

   task automatic bus_wr(input rtcwd_addr_type a, input rtcwd_byte_type d);
   begin
      @(posedge i_ref_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_ref_clk);
      i_wr    <= 1'b0;
      #1;
   end
   endtask : bus_wr

   // read data is looked at only in the one cycle that it stands
   task automatic bus_rd_chk(input rtcwd_addr_type a, input rtcwd_byte_type exp);
   begin
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_ref_clk);
      i_rd   <= 1'b0;
      #1;
      chk_val({24'h0, rdata}, {24'h0, exp});
   end
   endtask : bus_rd_chk

   task automatic toggle_pin();
   begin
      @(posedge i_ref_clk);
      tog <= 1'b1;
      @(posedge i_ref_clk);
      tog <= 1'b0;
      cycles(6);
   end
   endtask : toggle_pin

   task automatic port_set(input logic [7:0] v);
   begin
      @(posedge i_ref_clk);
      port_nx <= v;
      port_ld <= 1'b1;
      @(posedge i_ref_clk);
      port_ld <= 1'b0;
      cycles(6);
   end
   endtask : port_set

   // the release must also not come before the whole delay count has run
   task automatic wait_release();
      int k;
   begin
      k = 0;
      while (core_rst !== 1'b0 && k < 4000)
      begin
         cycles(1);
         k++;
      end
      chk_val({31'h0, core_rst}, 32'h0);
      chk_val({31'h0, pc_load}, 32'h1);
      chk_val({21'h0, pc_vec}, {21'h0, `RTCWD_RESET_VECTOR});
      chk_val({31'h0, k >= DRT * 1024}, 32'h1);
   end
   endtask : wait_release

   task automatic next_pulse(input int bound);
   begin
      n = 0;
      do
      begin
         cycles(1);
         n++;
      end
      while (roll_irq !== 1'b1 && n < bound);
   end
   endtask : next_pulse

   // the first pulse may belong to the old setting, so the gap is taken later
   task automatic roll_gap(input rtcwd_byte_type opt, input int period);
   begin
      bus_wr(`RTCWD_ADDR_OPTION, opt);
      next_pulse(2 * period + 20);
      next_pulse(period + 20);
      next_pulse(period + 20);
      chk_val(n, period);
   end
   endtask : roll_gap

   initial
   begin
      #720000;
      mismatches++;
      end_of_test();
   end

   initial
   begin
      cycles(20);
      i_rst <= 1'b0;
      cycles(100);
      chk_val({31'h0, core_rst}, 32'h1);
      ext_n <= 1'b1;
      wait_release();
      chk_val({30'h0, to_flag, pd_flag}, 32'h3);
      bus_rd_chk(`RTCWD_ADDR_STATUS, 8'h18);
      bus_rd_chk(`RTCWD_ADDR_MASK, `RTCWD_EDGE_REG_RST);
      bus_rd_chk(`RTCWD_ADDR_POLARITY, `RTCWD_EDGE_REG_RST);
      bus_rd_chk(`RTCWD_ADDR_OPTION, `RTCWD_OPTION_RST);
      bus_rd_chk(3'h7, 8'h00);
      bus_rd_chk(`RTCWD_ADDR_COMMAND, 8'h00);
      bus_wr(`RTCWD_ADDR_PENDING, 8'h00);
      bus_wr(`RTCWD_ADDR_POLARITY, 8'h0f);
      bus_wr(`RTCWD_ADDR_MASK, 8'h55);
      port_set(8'hff);
      bus_rd_chk(`RTCWD_ADDR_PENDING, 8'ha0);
      chk_val({31'h0, edge_irq}, 32'h1);
      port_set(8'h00);
      bus_rd_chk(`RTCWD_ADDR_PENDING, 8'haa);
      bus_wr(`RTCWD_ADDR_PENDING, 8'h00);
      bus_rd_chk(`RTCWD_ADDR_PENDING, 8'h00);
      chk_val({31'h0, edge_irq}, 32'h0);
      bus_wr(`RTCWD_ADDR_OPTION, 8'h28);
      bus_wr(`RTCWD_ADDR_COUNTER, 8'h00);
      toggle_pin();
      bus_rd_chk(`RTCWD_ADDR_COUNTER, 8'h01);
      toggle_pin();
      bus_rd_chk(`RTCWD_ADDR_COUNTER, 8'h01);
      bus_wr(`RTCWD_ADDR_OPTION, 8'h38);
      toggle_pin();
      bus_rd_chk(`RTCWD_ADDR_COUNTER, 8'h01);
      toggle_pin();
      bus_rd_chk(`RTCWD_ADDR_COUNTER, 8'h02);
      roll_gap(8'h48, 256);
      for (int r = 0; r < 5; r++)
      begin
         roll_gap(8'h40 + r[7:0], 256 << (r + 1));
      end
      bus_wr(`RTCWD_ADDR_OPTION, 8'h08);
      next_pulse(600);
      chk_val(n, 600);
      opt_ext <= 1'b1;
      cycles(4);
      bus_wr(`RTCWD_ADDR_OPTION, 8'h00);
      bus_rd_chk(`RTCWD_ADDR_OPTION, 8'hc0);
      opt_ext <= 1'b0;
      cycles(4);
      bus_wr(`RTCWD_ADDR_OPTION, 8'h00);
      bus_rd_chk(`RTCWD_ADDR_OPTION, 8'h00);
      for (int i = 0; i < 2; i++)
      begin
         if (i == 0)
         begin
            ext_n <= 1'b0;
         end
         else
         begin
            brown <= 1'b1;
         end
         cycles(8);
         chk_val({31'h0, core_rst}, 32'h1);
         ext_n <= 1'b1;
         brown <= 1'b0;
         wait_release();
         bus_rd_chk(`RTCWD_ADDR_MASK, `RTCWD_EDGE_REG_RST);
      end
      bus_wr(`RTCWD_ADDR_COMMAND, 8'h02);
      chk_val({30'h0, to_flag, pd_flag}, 32'h2);
      bus_wr(`RTCWD_ADDR_COMMAND, 8'h01);
      chk_val({30'h0, to_flag, pd_flag}, 32'h3);
      bus_wr(`RTCWD_ADDR_OPTION, 8'h00);
      wd_fuse <= 1'b1;
      repeat (5)
      begin
         cycles(100);
         bus_wr(`RTCWD_ADDR_COMMAND, 8'h01);
      end
      chk_val({31'h0, core_rst}, 32'h0);
      n = 0;
      while (core_rst !== 1'b1 && n < 400)
      begin
         cycles(1);
         n++;
      end
      chk_val({30'h0, core_rst, to_flag}, 32'h2);
      wd_fuse <= 1'b0;
      wait_release();
      bus_wr(`RTCWD_ADDR_COMMAND, 8'h01);
      chk_val({30'h0, to_flag, pd_flag}, 32'h3);
      end_of_test();
   end
endmodule : rtcwd_unit_bench

`default_nettype wire

// File: verilog/rtcwd_consts.svh
// How it works
// [R1] eight-bit counter steps per cycle or pin edge
// [R2] option bit 5 picks pin clock
// [R3] option bit 4 set counts falling edges
// [R4] wrap to zero requests interrupt, no flag
// [R5] rollover interrupt gated by enable bit
// [R6] prescaler ahead of counter gives 16 bits
// [R7] option bit 3 moves prescaler to watchdog
// [R8] three-bit rate field sets division ratio
// [R9] prescaler value never readable or writable
// [R10] prescaler serves counter or watchdog, never both
// [R11] eight port edge interrupts, clear bit enables
// [R12] polarity bit set means falling edge
// [R13] mask and polarity reset to all ones
// [R14] qualifying enabled edge sets pending bit
// [R15] software clears pending before enabling interrupts
// [R16] every reset loads top program address
// [R17] delay timer starts once reset pin high
// [R18] delay terminal count releases reset latch
// [R19] timeout clears flag; clear/sleep set it
// [R20] watchdog clear zeroes counters, sets flags
// [R21] extension fuse forces option bits 7:6 high
// [R22] pins synchronised before edge detection
// [R23] watchdog terminal count asserts internal reset
`ifndef RTCWD_CONSTS_SVH
`define RTCWD_CONSTS_SVH

`define RTCWD_ADDR_OPTION     3'h0
`define RTCWD_ADDR_COUNTER    3'h1
`define RTCWD_ADDR_MASK       3'h2
`define RTCWD_ADDR_POLARITY   3'h3
`define RTCWD_ADDR_PENDING    3'h4
`define RTCWD_ADDR_STATUS     3'h5
`define RTCWD_ADDR_COMMAND    3'h6

`define RTCWD_OPT_MAP         7
`define RTCWD_OPT_IRQEN       6
`define RTCWD_OPT_CLKSRC      5
`define RTCWD_OPT_EDGE        4
`define RTCWD_OPT_PSA         3
`define RTCWD_OPT_RATE_MSB    2

`define RTCWD_STAT_TIMEOUT    4
`define RTCWD_STAT_POWERDOWN  3
`define RTCWD_CMD_WDCLEAR     0
`define RTCWD_CMD_SLEEP       1

`define RTCWD_OPTION_RST      8'hff
`define RTCWD_EDGE_REG_RST    8'hff
`define RTCWD_PENDING_RST     8'h00
`define RTCWD_RESET_VECTOR    11'h7ff
`define RTCWD_DRT_LAST        10'h3ff

`define RTCWD_CLK_PERIOD_NS   8
`define RTCWD_DRT_TIME_NS     72000000
`define RTCWD_DRT_STEPS       1024
`define RTCWD_DRT_TICK_CYCLES \
   (`RTCWD_DRT_TIME_NS / (`RTCWD_CLK_PERIOD_NS * `RTCWD_DRT_STEPS))
`define RTCWD_WDT_TICK_CYCLES 64

`endif

// File: verilog/rtcwd_pkg.sv
package rtcwd_pkg;
   typedef logic [2:0]  rtcwd_addr_type;
   typedef logic [7:0]  rtcwd_byte_type;
   typedef logic [10:0] rtcwd_pc_type;
   typedef enum logic [1:0] {RST_WAIT_PIN, RST_DELAY, RST_RUN} rtcwd_rst_state_type;
endpackage : rtcwd_pkg

// File: verilog/rtcwd_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcwd_consts.svh"

module rtcwd_unit #(
   parameter int DRT_TICK_CYCLES = `RTCWD_DRT_TICK_CYCLES,
   parameter int WDT_TICK_CYCLES = `RTCWD_WDT_TICK_CYCLES
) (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst,
   input  wire rtcwd_pkg::rtcwd_addr_type i_addr,
   input  wire rtcwd_pkg::rtcwd_byte_type i_wdata,
   input  wire logic                    i_wr,
   input  wire logic                    i_rd,
   input  wire logic                    i_counter_pin,
   input  wire logic [7:0]              i_port_b,
   input  wire logic                    i_ext_reset_n,
   input  wire logic                    i_brownout,
   input  wire logic                    i_watchdog_fuse_enable,
   input  wire logic                    i_option_extend_disable,
   output var  rtcwd_pkg::rtcwd_byte_type o_rdata,
   output var  logic                    o_rollover_irq,
   output var  logic                    o_edge_irq,
   output var  logic                    o_core_reset,
   output var  logic                    o_pc_load,
   output var  rtcwd_pkg::rtcwd_pc_type o_pc_vector,
   output var  logic                    o_timeout_flag,
   output var  logic                    o_powerdown_flag
);
   import rtcwd_pkg::*;

   localparam int DTW = $clog2(DRT_TICK_CYCLES + 1);
   localparam int WTW = $clog2(WDT_TICK_CYCLES + 1);

   // mask of prescaler bits that must all be one for an output tick
   function automatic logic ps_hit(input logic [7:0] cnt, input logic [2:0] rate);
      logic [8:0] mask;
      mask = (9'h002 << rate) - 9'h001;
      ps_hit = &(cnt | ~mask[7:0]);
   endfunction : ps_hit

   function automatic logic [7:0] edges(input logic [7:0] prev, input logic [7:0] cur,
                                        input logic [7:0] falling);
      edges = (falling & prev & ~cur) | (~falling & ~prev & cur);
   endfunction : edges

   logic [2:0]          pin_sync;
   logic [7:0]          port_s1;
   logic [7:0]          port_s2;
   logic [7:0]          port_prev;
   logic [1:0]          extn_sync;
   logic [1:0]          bo_sync;
   logic [1:0]          wden_sync;
   logic [1:0]          optx_sync;
   rtcwd_rst_state_type state;
   rtcwd_rst_state_type next_state;
   logic [DTW-1:0]      drt_tick;
   logic [9:0]          drt;
   rtcwd_byte_type      option;
   rtcwd_byte_type      opt_eff;
   rtcwd_byte_type      edge_irq_mask;
   rtcwd_byte_type      edge_polarity_sel;
   rtcwd_byte_type      edge_irq_pending;
   rtcwd_byte_type      next_pending;
   rtcwd_byte_type      rt_counter;
   rtcwd_byte_type      prescaler;
   rtcwd_byte_type      watchdog_counter;
   logic [WTW-1:0]      wdt_tick_cnt;
   logic [7:0]          pin_edges;
   logic [7:0]          port_hits;
   logic                in_reset;
   logic                wr_ok;
   logic                wd_clear;
   logic                sleep_op;
   logic                cnt_event;
   logic                prescaler_assign;
   logic                wdt_tick;
   logic                wdt_wrap;
   logic                ps_inc;
   logic                ps_out;
   logic                rt_step;
   logic                wdt_timeout;
   logic                drt_step;
   logic                hard_req;
   logic                wr_cnt;

   // [R22] two-stage synchronisers
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_sync  <= 3'h0;
         port_s1   <= 8'h00;
         port_s2   <= 8'h00;
         port_prev <= 8'h00;
         extn_sync <= 2'h0;
         bo_sync   <= 2'h0;
         wden_sync <= 2'h0;
         optx_sync <= 2'h0;
      end
      else
      begin
         pin_sync  <= {pin_sync[1:0], i_counter_pin};
         port_s1   <= i_port_b;
         port_s2   <= port_s1;
         port_prev <= port_s2;
         extn_sync <= {extn_sync[0], i_ext_reset_n};
         bo_sync   <= {bo_sync[0], i_brownout};
         wden_sync <= {wden_sync[0], i_watchdog_fuse_enable};
         optx_sync <= {optx_sync[0], i_option_extend_disable};
      end
   end

   assign in_reset = (state != RST_RUN);
   assign wr_ok    = i_wr && !in_reset;
   assign wr_cnt   = wr_ok && (i_addr == `RTCWD_ADDR_COUNTER);
   assign wd_clear = wr_ok && (i_addr == `RTCWD_ADDR_COMMAND) && i_wdata[`RTCWD_CMD_WDCLEAR];
   assign sleep_op = wr_ok && (i_addr == `RTCWD_ADDR_COMMAND) && i_wdata[`RTCWD_CMD_SLEEP];

   // [R21] fuse forces map and irq enable high
   always_comb
   begin
      opt_eff = option;
      opt_eff[`RTCWD_OPT_MAP]   = option[`RTCWD_OPT_MAP] | optx_sync[1];
      opt_eff[`RTCWD_OPT_IRQEN] = option[`RTCWD_OPT_IRQEN] | optx_sync[1];
   end

   // [R3] edge select on counter pin
   assign pin_edges = edges({8{pin_sync[2]}}, {8{pin_sync[1]}}, {8{opt_eff[`RTCWD_OPT_EDGE]}});
   // [R2] clock source select
   assign cnt_event = opt_eff[`RTCWD_OPT_CLKSRC] ? pin_edges[0] : 1'b1;
   assign prescaler_assign       = opt_eff[`RTCWD_OPT_PSA];

   assign wdt_tick = (wdt_tick_cnt == WTW'(WDT_TICK_CYCLES - 1));
   assign wdt_wrap = wden_sync[1] && wdt_tick && (watchdog_counter == 8'hff) && !in_reset;
   // [R7] prescaler routing
   // [R10] one user of the prescaler at a time
   assign ps_inc  = prescaler_assign ? wdt_wrap : cnt_event;
   // [R8] rate field picks the divide ratio
   assign ps_out  = ps_inc && ps_hit(prescaler, opt_eff[`RTCWD_OPT_RATE_MSB:0]);
   // [R6] prescaler extends the counter chain
   assign rt_step = prescaler_assign ? cnt_event : ps_out;
   // [R23] watchdog terminal count
   assign wdt_timeout = (prescaler_assign ? ps_out : wdt_wrap) && !wd_clear;

   // [R9] prescaler has no bus path
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         prescaler <= 8'h00;
      else if (in_reset || (wd_clear && prescaler_assign))
         prescaler <= 8'h00;
      else if (ps_inc)
         prescaler <= prescaler + 8'h01;
   end

   // slow tick stands in for the watchdog's own oscillator
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         wdt_tick_cnt <= '0;
      else if (wdt_tick)
         wdt_tick_cnt <= '0;
      else
         wdt_tick_cnt <= wdt_tick_cnt + WTW'(1);
   end

   // [R20] clear op zeroes the watchdog
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         watchdog_counter <= 8'h00;
      else if (in_reset || wd_clear)
         watchdog_counter <= 8'h00;
      else if (wden_sync[1] && wdt_tick)
         watchdog_counter <= watchdog_counter + 8'h01;
   end

   // [R1] real-time counter, a write wins over a step
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         rt_counter <= 8'h00;
      else if (in_reset)
         rt_counter <= 8'h00;
      else if (wr_cnt)
         rt_counter <= i_wdata;
      else if (rt_step)
         rt_counter <= rt_counter + 8'h01;
   end

   // [R4] wrap pulse, nothing is latched
   // [R5] gated by the enable bit
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         o_rollover_irq <= 1'b0;
      else
         o_rollover_irq <= rt_step && !wr_cnt && !in_reset && (rt_counter == 8'hff)
                           && opt_eff[`RTCWD_OPT_IRQEN];
   end

   // [R13] mask and polarity load all ones on any reset
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         option            <= `RTCWD_OPTION_RST;
         edge_irq_mask     <= `RTCWD_EDGE_REG_RST;
         edge_polarity_sel <= `RTCWD_EDGE_REG_RST;
      end
      else if (in_reset)
      begin
         option            <= `RTCWD_OPTION_RST;
         edge_irq_mask     <= `RTCWD_EDGE_REG_RST;
         edge_polarity_sel <= `RTCWD_EDGE_REG_RST;
      end
      else if (wr_ok)
      begin
         if (i_addr == `RTCWD_ADDR_OPTION)
            option <= i_wdata;
         if (i_addr == `RTCWD_ADDR_MASK)
            edge_irq_mask <= i_wdata;
         if (i_addr == `RTCWD_ADDR_POLARITY)
            edge_polarity_sel <= i_wdata;
      end
   end

   // [R12] per-pin polarity
   // [R11] cleared mask bit enables the pin
   assign port_hits = edges(port_prev, port_s2, edge_polarity_sel) & ~edge_irq_mask;

   // [R14] edge sets pending; a same-cycle write cannot drop it
   always_comb
   begin
      next_pending = edge_irq_pending;
      if (wr_ok && (i_addr == `RTCWD_ADDR_PENDING))
         next_pending = i_wdata;
      next_pending = next_pending | port_hits;
   end

   // pending survives core resets; software must clear it before use
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         edge_irq_pending <= `RTCWD_PENDING_RST;
         o_edge_irq       <= 1'b0;
      end
      else
      begin
         edge_irq_pending <= next_pending;
         o_edge_irq       <= |next_pending;
      end
   end

   // [R19] timeout clears, clear op and sleep set
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_timeout_flag   <= 1'b1;
         o_powerdown_flag <= 1'b1;
      end
      else
      begin
         if (wdt_timeout)
            o_timeout_flag <= 1'b0;
         else if (wd_clear || sleep_op)
            o_timeout_flag <= 1'b1;
         if (wd_clear)
            o_powerdown_flag <= 1'b1;
         else if (sleep_op)
            o_powerdown_flag <= 1'b0;
      end
   end

   assign hard_req = !extn_sync[1] || bo_sync[1] || wdt_timeout;
   assign drt_step = (drt_tick == DTW'(DRT_TICK_CYCLES - 1));

   // [R17] latch held until the reset pin reads high
   always_comb
   begin
      next_state = state;
      if (hard_req)
         next_state = RST_WAIT_PIN;
      else
      begin
         unique case (state)
            RST_WAIT_PIN: next_state = RST_DELAY;
            // [R18] terminal count releases the latch
            RST_DELAY:    if (drt_step && drt == `RTCWD_DRT_LAST) next_state = RST_RUN;
            RST_RUN:      next_state = RST_RUN;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state    <= RST_WAIT_PIN;
         drt_tick <= '0;
         drt      <= 10'h000;
      end
      else
      begin
         state <= next_state;
         if (next_state != RST_DELAY || drt_step)
            drt_tick <= '0;
         else
            drt_tick <= drt_tick + DTW'(1);
         if (next_state != RST_DELAY)
            drt <= 10'h000;
         else if (drt_step)
            drt <= drt + 10'h001;
      end
   end

   // [R16] reset vector loaded on every release
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_core_reset <= 1'b1;
         o_pc_load    <= 1'b0;
         o_pc_vector  <= `RTCWD_RESET_VECTOR;
      end
      else
      begin
         o_core_reset <= (next_state != RST_RUN);
         o_pc_load    <= in_reset && (next_state == RST_RUN);
         o_pc_vector  <= `RTCWD_RESET_VECTOR;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (!i_rd)
         o_rdata <= 8'h00;
      else
      begin
         unique case (i_addr)
            `RTCWD_ADDR_OPTION:   o_rdata <= opt_eff;
            `RTCWD_ADDR_COUNTER:  o_rdata <= rt_counter;
            `RTCWD_ADDR_MASK:     o_rdata <= edge_irq_mask;
            `RTCWD_ADDR_POLARITY: o_rdata <= edge_polarity_sel;
            `RTCWD_ADDR_PENDING:  o_rdata <= edge_irq_pending;
            `RTCWD_ADDR_STATUS:   o_rdata <= {3'h0, o_timeout_flag, o_powerdown_flag, 3'h0};
            default:              o_rdata <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   chk_internal_count: assert property ( // [R1]
      (!in_reset && !opt_eff[`RTCWD_OPT_CLKSRC] && prescaler_assign && !wr_cnt && !hard_req)
      |=> rt_counter == $past(rt_counter) + 8'h01)
      else $error("counter did not step on internal clock");
   chk_pin_idle: assert property ( // [R3]
      (!in_reset && opt_eff[`RTCWD_OPT_CLKSRC] && prescaler_assign && !pin_edges[0] && !wr_cnt && !hard_req)
      |=> $stable(rt_counter))
      else $error("counter moved without a pin edge");
   chk_rollover_pulse: assert property ( // [R4]
      (!in_reset && rt_step && !wr_cnt && rt_counter == 8'hff && opt_eff[`RTCWD_OPT_IRQEN])
      |=> o_rollover_irq ##1 !o_rollover_irq || $past(rt_step, 1) && rt_counter == 8'h00)
      else $error("rollover interrupt missing");
   chk_irq_gate: assert property ( // [R5]
      !opt_eff[`RTCWD_OPT_IRQEN] |=> !o_rollover_irq)
      else $error("rollover interrupt while disabled");
   chk_prescale_half: assert property ( // [R6]
      (!in_reset && !prescaler_assign && !opt_eff[`RTCWD_OPT_CLKSRC] && opt_eff[2:0] == 3'h0
       && rt_step && !wr_ok && !hard_req)
      |=> !rt_step)
      else $error("divide by two broken");
   chk_port_pending: assert property ( // [R14]
      |port_hits |=> (edge_irq_pending & $past(port_hits)) == $past(port_hits))
      else $error("edge did not set pending");
   chk_reset_ones: assert property ( // [R13]
      in_reset |=> edge_irq_mask == 8'hff && edge_polarity_sel == 8'hff)
      else $error("mask or polarity not all ones");
   chk_release_count: assert property ( // [R18]
      $fell(o_core_reset) |-> $past(drt) == `RTCWD_DRT_LAST && o_pc_load)
      else $error("released before terminal count");
   chk_wdt_clear: assert property ( // [R20]
      wd_clear |=> watchdog_counter == 8'h00 && o_timeout_flag && o_powerdown_flag)
      else $error("watchdog clear incomplete");
   chk_timeout_reset: assert property ( // [R23]
      wdt_timeout |=> !o_timeout_flag && o_core_reset && state == RST_WAIT_PIN)
      else $error("watchdog timeout did not reset");
   chk_fuse_force: assert property ( // [R21]
      (i_rd && i_addr == `RTCWD_ADDR_OPTION && optx_sync[1] && $stable(optx_sync[1]))
      |=> o_rdata[7:6] == 2'b11)
      else $error("extension fuse did not force bits");

   cov_rollover: cover property (o_rollover_irq);
   cov_timeout:  cover property (wdt_timeout);
   cov_release:  cover property ($fell(o_core_reset));
   cov_edge:     cover property ($rose(o_edge_irq));

endmodule : rtcwd_unit
`default_nettype wire
